// ### hdl/ssi_core.sv
// Purpose: Status LEDs and text display sequencing for two functions.
// Assumes: All status inputs come from logic on sys_clk_i.
// Notes: Text is scanned one position per cycle over 24 positions.
// Summary of operation
// - Six LEDs: 1..3 for function A, 4..6 for function B.
// - LEDs 1,6: dark unpowered, red off, red blink error, green on.
// - LEDs 2,5: off free/enabled, blink field occupied, on blocked.
// - LEDs 3,4: lit while the warning field is interrupted.
// - Normal operation shows the monitored field pair.
// - Unconfigured boot cycles identity screens, then shows level.
// - Download shows awaiting, then downloading while data moves.
// - Level screen shows signed whole degrees labelled H and V.
// - Ping shows a ping message followed by the device name.
// - Errors show category letter F E U I P then a number.
// - Non-locking errors recover after 10 s without restart.
// - Blocking errors stay latched until power is cycled.
// - Field free about 5 s returns to normal display unless a blocking error is latched.
// - Display can be blanked or rotated by 180 degrees.
`timescale 1ns/100ps
module ssi_core #(
    parameter int BLINK_CYC = ssi_pkg::BLINK_CYC,
    parameter int RECOVER_CYC = ssi_pkg::RECOVER_CYC,
    parameter int FREE_CYC = ssi_pkg::FREE_CYC,
    parameter int BOOT_STEP_CYC = ssi_pkg::BOOT_STEP_CYC
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic [1:0] output_on_i,
    input wire logic [1:0] interlock_en_i,
    input wire logic [1:0] interlock_blocked_i,
    input wire logic [1:0] field_occupied_i,
    input wire logic [1:0] warn_interrupted_i,
    input wire logic configured_i,
    input wire logic booting_i,
    input wire logic dl_await_i,
    input wire logic dl_active_i,
    input wire logic ping_i,
    input wire logic err_event_i,
    input wire logic err_blocking_i,
    input wire logic [2:0] err_cat_i,
    input wire logic [11:0] err_code_i,
    input wire logic [7:0] field_pair_i,
    input wire logic [7:0] tilt_h_i,
    input wire logic [7:0] tilt_v_i,
    input wire logic [7:0] ident_char_i,
    input wire logic disp_off_i,
    input wire logic disp_rot_i,
    output logic [5:0] led_red_o,
    output logic [5:0] led_on_o,
    output logic recover_o,
    output logic error_o,
    output logic [3:0] screen_o,
    output logic [4:0] char_pos_o,
    output logic [7:0] char_o,
    output logic rotate_o
);
    logic [31:0] blink_cnt;
    logic blink;
    logic [31:0] rec_cnt;
    logic [31:0] free_cnt;
    logic [31:0] boot_cnt;
    logic [2:0] boot_idx;
    logic err_active;
    logic err_lock;
    logic [2:0] err_cat;
    logic [11:0] err_code;
    logic ping_hold;
    logic [4:0] scan;
    logic [3:0] next_screen;
    logic [3:0] screen;
    logic [7:0] text_char;
    logic [4:0] text_pos;
    logic [7:0] ping_char;
    logic [5:0] next_led_on;
    logic [5:0] next_led_red;
    logic all_free;
    logic rec_done;
    logic free_done;

    // Blink divider, fixed half period
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            blink_cnt <= '0;
            blink <= 1'b0;
        end else if (blink_cnt == 32'(BLINK_CYC - 1)) begin
            blink_cnt <= '0;
            blink <= ~blink;
        end else begin
            blink_cnt <= blink_cnt + 32'h1;
        end
    end

    assign all_free = ~|field_occupied_i;
    assign rec_done = (rec_cnt == 32'(RECOVER_CYC - 1));
    assign free_done = (free_cnt == 32'(FREE_CYC - 1));

    // Error latch; a blocking error only leaves through reset
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            err_active <= 1'b0;
            err_lock <= 1'b0;
            err_cat <= 3'h0;
            err_code <= 12'h000;
            rec_cnt <= '0;
        end else if (err_event_i) begin
            err_active <= 1'b1; // New error wins over recovery
            err_lock <= err_lock | err_blocking_i;
            err_cat <= err_cat_i;
            err_code <= err_code_i;
            rec_cnt <= '0;
        end else if (err_active && !err_lock) begin
            if (rec_done) begin
                err_active <= 1'b0;
                rec_cnt <= '0;
            end else begin
                rec_cnt <= rec_cnt + 32'h1;
            end
        end
    end

    // Recovery pulse; outputs stay off, restart still needs the interlock
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            recover_o <= 1'b0;
            error_o <= 1'b0;
        end else begin
            recover_o <= err_active && !err_lock && rec_done
                         && !err_event_i;
            error_o <= err_active;
        end
    end

    // Field-free timer for falling back to normal display
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            free_cnt <= '0;
        end else if (!all_free || err_event_i || ping_i) begin
            free_cnt <= '0;
        end else if (!free_done) begin
            free_cnt <= free_cnt + 32'h1;
        end
    end

    // Ping message held until the field-free timeout
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ping_hold <= 1'b0;
        end else if (ping_i) begin
            ping_hold <= 1'b1; // Set wins over clear
        end else if (free_done) begin
            ping_hold <= 1'b0;
        end
    end

    // Boot screen stepper over seven identity screens
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            boot_cnt <= '0;
            boot_idx <= 3'h0;
        end else if (!booting_i) begin
            boot_cnt <= '0;
            boot_idx <= 3'h0;
        end else if (boot_cnt == 32'(BOOT_STEP_CYC - 1)) begin
            boot_cnt <= '0;
            boot_idx <= (boot_idx == ssi_pkg::BOOT_LAST) ? 3'h0
                        : boot_idx + 3'h1;
        end else begin
            boot_cnt <= boot_cnt + 32'h1;
        end
    end

    // Screen priority: blank, download, ping, error, boot, level, fields
    assign next_screen =
        disp_off_i ? ssi_pkg::SCR_BLANK :
        dl_await_i ? ssi_pkg::SCR_AWAIT :
        dl_active_i ? ssi_pkg::SCR_DOWNLOAD :
        ping_hold ? ssi_pkg::SCR_PING :
        (err_active && (err_lock || !free_done)) ? ssi_pkg::SCR_ERROR :
        booting_i ? 4'(4'h1 + {1'b0, boot_idx}) :
        !configured_i ? ssi_pkg::SCR_LEVEL :
        ssi_pkg::SCR_FIELDS;

    // Rotation mirrors the scan order so glyphs land reversed
    assign text_pos = disp_rot_i ? 5'(5'd23 - scan) : scan;
    // Ping screen: marker, then device name from identity source
    assign ping_char = (text_pos == 5'd0) ? 8'h50 : ident_char_i;

    ssi_text u_text (
        .screen_i(screen),
        .pos_i(text_pos),
        .field_pair_i(field_pair_i),
        .tilt_h_i(tilt_h_i),
        .tilt_v_i(tilt_v_i),
        .err_cat_i(err_cat),
        .err_code_i(err_code),
        .ident_char_i(ident_char_i),
        .char_o(text_char)
    );

    // Character scanner, one position per cycle
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            scan <= 5'h00;
            screen <= 4'h0;
            screen_o <= 4'h0;
            char_pos_o <= 5'h00;
            char_o <= 8'h20;
            rotate_o <= 1'b0;
        end else begin
            scan <= (scan == 5'(ssi_pkg::NCHAR - 1)) ? 5'h00 : scan + 5'h01;
            screen <= next_screen;
            screen_o <= screen;
            char_pos_o <= scan;
            char_o <= (screen == ssi_pkg::SCR_PING) ? ping_char
                      : text_char;
            rotate_o <= disp_rot_i;
        end
    end

    // LED colours per function; index 0..2 function A, 3..5 function B
    always_comb begin
        next_led_on = 6'h00;
        next_led_red = 6'h00;
        // Output state LEDs 1 and 6
        next_led_on[0] = err_active ? blink : 1'b1;
        next_led_red[0] = err_active || !output_on_i[0];
        next_led_on[5] = err_active ? blink : 1'b1;
        next_led_red[5] = err_active || !output_on_i[1];
        // Interlock LEDs 2 and 5
        next_led_on[1] = interlock_en_i[0] & (field_occupied_i[0] ? blink
                         : interlock_blocked_i[0]);
        next_led_on[4] = interlock_en_i[1] & (field_occupied_i[1] ? blink
                         : interlock_blocked_i[1]);
        // Warning field LEDs 3 and 4
        next_led_on[2] = warn_interrupted_i[0];
        next_led_on[3] = warn_interrupted_i[1];
    end

    // Registered LED drive; all dark in reset, LEDs 1 and 6 also dark in the error blink off phase
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            led_on_o <= 6'h00;
            led_red_o <= 6'h00;
        end else begin
            led_on_o <= next_led_on;
            led_red_o <= next_led_red;
        end
    end
endmodule

// ### hdl/ssi_pkg.sv
// Purpose: Shared constants for the status indicator block.
// Assumes: 100 MHz system clock.
// Notes: Screen codes and error letters used by core and text generator.
package ssi_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int BLINK_MS = 250;
    localparam int BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;
    localparam int RECOVER_S = 10;
    localparam int RECOVER_CYC = CLK_HZ * RECOVER_S;
    localparam int FREE_S = 5;
    localparam int FREE_CYC = CLK_HZ * FREE_S;
    localparam int BOOT_STEP_MS = 1000;
    localparam int BOOT_STEP_CYC = CLK_HZ / 1000 * BOOT_STEP_MS;
    localparam int NCHAR = 24;
    localparam logic [2:0] BOOT_LAST = 3'h6;

    typedef enum logic [3:0] {
        SCR_BLANK = 4'h0,
        SCR_TYPE = 4'h1,
        SCR_VERSION = 4'h2,
        SCR_SERIAL = 4'h3,
        SCR_NAME = 4'h4,
        SCR_ADDRESS = 4'h5,
        SCR_WIRELESS = 4'h6,
        SCR_CFG_REQ = 4'h7,
        SCR_LEVEL = 4'h8,
        SCR_AWAIT = 4'h9,
        SCR_DOWNLOAD = 4'ha,
        SCR_PING = 4'hb,
        SCR_ERROR = 4'hc,
        SCR_FIELDS = 4'hd
    } ssi_screen_t;

    typedef enum logic [2:0] {
        ERR_FAIL = 3'h0,
        ERR_EXTERNAL = 3'h1,
        ERR_USAGE = 3'h2,
        ERR_INFO = 3'h3,
        ERR_PARAM = 3'h4
    } ssi_err_cat_t;
endpackage

// ### hdl/ssi_text.sv
// Purpose: Character generator for one 24-position text screen.
// Assumes: Screen code and data fields stable while read.
// Notes: Combinational; the core registers the result.
`timescale 1ns/100ps
module ssi_text (
    input wire logic [3:0] screen_i,
    input wire logic [4:0] pos_i,
    input wire logic [7:0] field_pair_i,
    input wire logic [7:0] tilt_h_i,
    input wire logic [7:0] tilt_v_i,
    input wire logic [2:0] err_cat_i,
    input wire logic [11:0] err_code_i,
    input wire logic [7:0] ident_char_i,
    output logic [7:0] char_o
);
    // Hex digit to ASCII, used for several numeric fields
    function automatic logic [7:0] hex_ch(input logic [3:0] d);
        return (d < 4'ha) ? (8'h30 + {4'h0, d}) : (8'h37 + {4'h0, d});
    endfunction

    // Sign character for a two's complement tilt
    function automatic logic [7:0] sgn_ch(input logic [7:0] v);
        return v[7] ? 8'h2d : 8'h2b;
    endfunction

    // Magnitude tens/units digit of a signed degree value
    function automatic logic [7:0] deg_dig(input logic [7:0] v,
                                           input logic tens);
        logic [7:0] m;
        m = v[7] ? (8'h00 - v) : v;
        return tens ? (8'h30 + (m / 8'h0a)) : (8'h30 + (m % 8'h0a));
    endfunction

    logic [7:0] letter;
    // Error category letter F E U I P
    assign letter = (err_cat_i == 3'h0) ? 8'h46 :
                    (err_cat_i == 3'h1) ? 8'h45 :
                    (err_cat_i == 3'h2) ? 8'h55 :
                    (err_cat_i == 3'h3) ? 8'h49 : 8'h50;

    // Screen text selection by position
    always_comb begin
        char_o = 8'h20;
        case (screen_i)
            4'h8: begin // Level screen H sdd V sdd
                case (pos_i)
                    5'd0: char_o = 8'h48;
                    5'd1: char_o = sgn_ch(tilt_h_i);
                    5'd2: char_o = deg_dig(tilt_h_i, 1'b1);
                    5'd3: char_o = deg_dig(tilt_h_i, 1'b0);
                    5'd5: char_o = 8'h56;
                    5'd6: char_o = sgn_ch(tilt_v_i);
                    5'd7: char_o = deg_dig(tilt_v_i, 1'b1);
                    5'd8: char_o = deg_dig(tilt_v_i, 1'b0);
                    default: char_o = 8'h20;
                endcase
            end
            4'hc: begin // Letter then number code
                case (pos_i)
                    5'd0: char_o = letter;
                    5'd1: char_o = hex_ch(err_code_i[11:8]);
                    5'd2: char_o = hex_ch(err_code_i[7:4]);
                    5'd3: char_o = hex_ch(err_code_i[3:0]);
                    default: char_o = 8'h20;
                endcase
            end
            4'hd: begin // Active field pair
                case (pos_i)
                    5'd0: char_o = hex_ch(field_pair_i[7:4]);
                    5'd1: char_o = 8'h2e;
                    5'd2: char_o = hex_ch(field_pair_i[3:0]);
                    default: char_o = 8'h20;
                endcase
            end
            4'h0: char_o = 8'h20;
            default: char_o = ident_char_i; // Identity text from outside
        endcase
    end
endmodule

// ### tb/ssi_core_sva.sv
// Purpose: Port-level checks for the status indicator core.
// Assumes: Shortened counts handed on by the bind.
// Notes: Helper counters time recovery and blink runs.
`timescale 1ns/100ps
module ssi_core_sva #(
    parameter int BLINK_CYC = 4,
    parameter int RECOVER_CYC = 50
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic [1:0] output_on_i,
    input wire logic [1:0] interlock_en_i,
    input wire logic [1:0] field_occupied_i,
    input wire logic [1:0] warn_interrupted_i,
    input wire logic dl_await_i,
    input wire logic dl_active_i,
    input wire logic err_event_i,
    input wire logic err_blocking_i,
    input wire logic [5:0] led_red_o,
    input wire logic [5:0] led_on_o,
    input wire logic recover_o,
    input wire logic error_o,
    input wire logic [3:0] screen_o
);
    localparam int RLO = RECOVER_CYC - 3;
    localparam int RHI = RECOVER_CYC + 1;
    logic blk;
    logic nb;
    logic flash_q;
    logic led_q;
    int age;
    int run;

    default clocking dc @(posedge sys_clk_i);
    endclocking
    default disable iff (!reset_n_i);

    // Error history and blink run; age saturates so it never wraps
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            blk <= 1'b0;
            nb <= 1'b0;
            flash_q <= 1'b0;
            led_q <= 1'b0;
            age <= 1023;
            run <= 0;
        end else begin
            if (err_event_i) begin
                blk <= blk | err_blocking_i;
                nb <= !err_blocking_i;
                age <= 0;
            end else if (age < 1023) begin
                age <= age + 1;
            end
            flash_q <= interlock_en_i[1] & field_occupied_i[1];
            led_q <= led_on_o[4];
            run <= (flash_q && led_q == led_on_o[4]) ? run + 1 : 0;
        end
    end

    // LED follows its cause one cycle later
    property p_blue_a; warn_interrupted_i[0] |=> led_on_o[2]; endproperty
    a_blue_a: assert property (p_blue_a) else $error("blue lag");
    // An event one cycle back has already set the latch behind error_o
    property p_green_a;
        output_on_i[0] && !error_o && !err_event_i && !$past(err_event_i)
            |=> led_on_o[0] && !led_red_o[0];
    endproperty
    a_green_a: assert property (p_green_a) else $error("green");
    property p_yel_off; !interlock_en_i[1] |=> !led_on_o[4]; endproperty
    a_yel_off: assert property (p_yel_off) else $error("yellow");
    // Latch then output register: flag and red LED show two edges later
    property p_err_rise; err_event_i |-> ##2 error_o && led_red_o[0]; endproperty
    a_err_rise: assert property (p_err_rise) else $error("err");
    // Error handling and its timing, plus the interlock LED blink run bound
    property p_block; blk && $past(blk) |-> error_o && !recover_o; endproperty
    a_block: assert property (p_block) else $error("unlatched");
    property p_recover; recover_o |-> nb && age >= RLO && age <= RHI; endproperty
    a_recover: assert property (p_recover) else $error("recover");
    property p_blink; run <= BLINK_CYC + 1; endproperty
    a_blink: assert property (p_blink) else $error("stuck blink");
    property p_err_scr;
        err_event_i && !dl_await_i && !dl_active_i |-> ##3 screen_o == 4'hc;
    endproperty
    a_err_scr: assert property (p_err_scr) else $error("err scr");
endmodule

bind ssi_core ssi_core_sva #(.BLINK_CYC(BLINK_CYC), .RECOVER_CYC(RECOVER_CYC))
    u_sva (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .output_on_i(output_on_i), .interlock_en_i(interlock_en_i),
    .field_occupied_i(field_occupied_i),
    .warn_interrupted_i(warn_interrupted_i), .dl_await_i(dl_await_i),
    .dl_active_i(dl_active_i), .err_event_i(err_event_i),
    .err_blocking_i(err_blocking_i), .led_red_o(led_red_o),
    .led_on_o(led_on_o), .recover_o(recover_o), .error_o(error_o),
    .screen_o(screen_o));

// ### tb/tb_top.sv
// Purpose: Self-checking bench for the status indicator core.
// Assumes: Inputs change on the falling clock edge.
// Notes: Counts are shortened through the core parameters.
`timescale 1ns/100ps
module tb_top;
    localparam int BC = 4;
    localparam int RC = 50;
    localparam int FC = 20;
    localparam int SC = 8;
    typedef struct packed {
        logic [1:0] on;
        logic [1:0] en;
        logic [1:0] blk;
        logic [1:0] warn;
        logic [5:0] led;
        logic [5:0] red;
    } ssi_row_t;
    logic sys_clk_i;
    logic reset_n_i;
    logic [1:0] on_i, en_i, blk_i, occ_i, warn_i;
    logic cfg_i, boot_i, aw_i, act_i, ping_i, ev_i, eb_i, off_i, rot_i;
    logic [2:0] cat_i;
    logic [11:0] code_i;
    logic [7:0] pair_i, th_i, tv_i, id_i, chr;
    logic [5:0] led_red, led_on;
    logic rec_o, err_o, rot_o;
    logic [3:0] scr;
    logic [4:0] pos;
    logic [7:0] txt [24];
    logic [7:0] prv [24];
    ssi_row_t rows [5];
    int n_errors = 0;
    int samples_checked = 0;
    int n;
    bit ok;
    string lt = "FEUIP";

    ssi_core #(.BLINK_CYC(BC), .RECOVER_CYC(RC), .FREE_CYC(FC),
        .BOOT_STEP_CYC(SC)) u_dut (
        .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .output_on_i(on_i),
        .interlock_en_i(en_i), .interlock_blocked_i(blk_i),
        .field_occupied_i(occ_i), .warn_interrupted_i(warn_i),
        .configured_i(cfg_i), .booting_i(boot_i), .dl_await_i(aw_i),
        .dl_active_i(act_i), .ping_i(ping_i), .err_event_i(ev_i),
        .err_blocking_i(eb_i), .err_cat_i(cat_i), .err_code_i(code_i),
        .field_pair_i(pair_i), .tilt_h_i(th_i), .tilt_v_i(tv_i),
        .ident_char_i(id_i), .disp_off_i(off_i), .disp_rot_i(rot_i),
        .led_red_o(led_red), .led_on_o(led_on), .recover_o(rec_o),
        .error_o(err_o), .screen_o(scr), .char_pos_o(pos), .char_o(chr),
        .rotate_o(rot_o));

    // Free-running 100 MHz clock
    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    // Shared helpers; every wait below is bounded
    task automatic chk(input bit c, input string m);
        samples_checked++;
        if (!c) begin
            n_errors++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge sys_clk_i);
    endtask
    task automatic report_and_stop;
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wscr(input logic [3:0] s, input int lim);
        int k;
        k = 0;
        while (scr !== s && k < lim) begin
            cyc(1);
            k++;
        end
        chk(scr === s, "screen code");
        if (scr !== s)
            report_and_stop();
    endtask
    task automatic grab;
        for (int k = 0; k < 26; k++) begin
            cyc(1);
            txt[pos] = chr;
        end
    endtask
    function automatic bit has(input string s);
        bit m;
        has = 0;
        for (int i = 0; i + s.len() <= 24; i++) begin
            m = 1;
            for (int j = 0; j < s.len(); j++)
                if (txt[i + j] !== s[j])
                    m = 0;
            if (m)
                has = 1;
        end
    endfunction
    // Measures successive half periods of one flashing LED
    task automatic half(input int b);
        logic v;
        for (int k = 0; k < 3; k++) begin
            n = 0;
            v = led_on[b];
            while (led_on[b] === v && n < 40) begin
                cyc(1);
                n++;
            end
            if (k > 0)
                chk(n == BC, "blink half period");
        end
    endtask

    // Hang guard
    initial begin
        cyc(20000);
        n_errors++;
        $display("BAD %0t watchdog", $time);
        report_and_stop();
    end

    // Main sequence: table of steady LED states, then hand-written cases
    initial begin
        reset_n_i = 1'b0;
        {on_i, en_i, blk_i, occ_i, warn_i} = 10'h000;
        {boot_i, aw_i, act_i, ping_i, ev_i, eb_i, off_i, rot_i} = 8'h00;
        cfg_i = 1'b1;
        cat_i = 3'h0;
        code_i = 12'h000;
        pair_i = 8'h37;
        th_i = 8'hfd;
        tv_i = 8'h09;
        id_i = 8'h4e;
        rows[0] = '{2'h0, 2'h0, 2'h0, 2'h0, 6'h21, 6'h21};
        rows[1] = '{2'h3, 2'h0, 2'h0, 2'h3, 6'h2d, 6'h00};
        rows[2] = '{2'h1, 2'h3, 2'h3, 2'h2, 6'h3b, 6'h20};
        rows[3] = '{2'h2, 2'h3, 2'h0, 2'h0, 6'h21, 6'h01};
        rows[4] = '{2'h0, 2'h0, 2'h3, 2'h1, 6'h25, 6'h21};
        cyc(4);
        ok = led_on === 6'h00 && chr === 8'h20 && err_o === 1'b0;
        chk(ok && scr === 4'h0, "reset state");
        cyc(4);
        reset_n_i = 1'b1;
        foreach (rows[i]) begin
            {on_i, en_i, blk_i, warn_i} = {rows[i].on, rows[i].en,
                rows[i].blk, rows[i].warn};
            cyc(3);
            chk(led_on === rows[i].led, "led lit");
            chk(led_red === rows[i].red, "led colour");
            chk(scr === ssi_pkg::SCR_FIELDS, "normal screen");
        end
        grab();
        chk(has("3.7"), "field pair text");
        prv = txt;
        rot_i = 1'b1;
        cyc(3);
        grab();
        ok = rot_o === 1'b1;
        for (int p = 0; p < 24; p++)
            ok &= txt[p] === prv[23 - p];
        chk(ok, "rotated text");
        {rot_i, off_i} = 2'h1;
        cyc(3);
        grab();
        ok = 1;
        foreach (txt[p])
            ok &= txt[p] === 8'h20;
        chk(ok, "blank text");
        // Both interlocks enabled and both fields occupied: both flash
        {off_i, blk_i, en_i, occ_i, on_i} = 9'h03d;
        half(1);
        ping_i = 1'b1;
        cyc(1);
        ping_i = 1'b0;
        wscr(ssi_pkg::SCR_PING, 4);
        grab();
        chk(txt[0] === 8'h50 && has("N"), "ping text");
        occ_i = 2'h0;
        cyc(FC - 4);
        chk(scr === ssi_pkg::SCR_PING, "ping held");
        wscr(ssi_pkg::SCR_FIELDS, 12);
        occ_i = 2'h1;
        for (int c = 0; c < 5; c++) begin
            cat_i = 3'(c);
            code_i = 12'h120 + 12'(c);
            ev_i = 1'b1;
            cyc(1);
            ev_i = 1'b0;
            cyc(1);
            chk(err_o === 1'b1, "error flag");
            cyc(1);
            grab();
            chk(has($sformatf("%s12%0d", lt.substr(c, c), c)), "code");
        end
        half(0);
        ev_i = 1'b1;
        cyc(1);
        ev_i = 1'b0;
        n = 0;
        while (rec_o !== 1'b1 && n < RC + 10) begin
            cyc(1);
            n++;
        end
        chk(n >= RC - 2 && n <= RC + 2, "recovery time");
        cyc(1);
        chk(err_o === 1'b0, "recovered");
        {eb_i, ev_i} = 2'h3;
        cyc(1);
        ev_i = 1'b0;
        ok = 1;
        repeat (RC + 10) begin
            cyc(1);
            ok &= rec_o === 1'b0;
        end
        chk(ok && err_o === 1'b1, "blocking latched");
        reset_n_i = 1'b0;
        {cfg_i, boot_i, eb_i} = 3'h2;
        cyc(2);
        chk(err_o === 1'b0, "power cycle clears");
        reset_n_i = 1'b1;
        wscr(ssi_pkg::SCR_TYPE, 4);
        for (int s = 2; s < 8; s++)
            wscr(4'(s), SC + 3);
        boot_i = 1'b0;
        wscr(ssi_pkg::SCR_LEVEL, 8 * SC);
        grab();
        chk(has("H-03 V+09"), "tilt");
        aw_i = 1'b1;
        wscr(ssi_pkg::SCR_AWAIT, 6);
        {aw_i, act_i} = 2'h1;
        wscr(ssi_pkg::SCR_DOWNLOAD, 6);
        act_i = 1'b0;
        report_and_stop();
    end
endmodule
